// ===== design/ppc_cfg.svh
// Offsets, field positions, codes, reset values and timing of the pulse processor
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH
// ==================================================
// Register byte offsets
`define OFS_PIN_DATA 12'h000
`define OFS_PIN_SET 12'h004
`define OFS_PIN_CLR 12'h008
`define OFS_PIN_DIR 12'h00C
`define OFS_VIRT_READ 12'h010
`define FUNC_REGION 3'h1
`define SUB_MODE 2'h0
`define SUB_SEL 2'h1
`define SUB_WORK 2'h2
`define SUB_AUX 2'h3
// ==================================================
// Field positions
`define MODE_LSB 0
`define OPOL_BIT 8
`define IEDG_LSB 12
`define TEDG_LSB 16
`define OP_LSB 0
`define IP_LSB 8
`define TP_LSB 16
`define GP_LSB 24
// ==================================================
// Mode, edge and pin codes
`define MODE_PIN_IO 7'h00
`define MODE_IDLE 7'h01
`define MODE_INC 7'h02
`define MODE_HALF 7'h03
`define MODE_WIDTH 7'h04
`define MODE_GATED 7'h05
`define MODE_LAST 7'h10
`define MODE_DOWN 7'h64
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
`define PIN_LAST 7'h40
`define CNT_MAX 16'hFFFF
// ==================================================
// Reset values and timing
`define DIR_RST 4'h0
`define STATIC_RST 32'h0000_0000
`define WORD_RST 16'h0000
`define CLK_PERIOD_NS 10
`define CYCLE_PERIOD_NS 5000
`define CYCLE_HALF_CNT (`CYCLE_PERIOD_NS / (2 * `CLK_PERIOD_NS))
`endif

// ===== design/ppc_pkg.sv
// Types shared by the pulse processor modules
package ppc_pkg;
    // Per-function operating settings
    typedef struct packed {
        logic [1:0] tedg;
        logic [1:0] iedg;
        logic opol;
        logic [6:0] mode;
    } func_cfg_s;
    // Pin selections, each 0..64
    typedef struct packed {
        logic [6:0] gp;
        logic [6:0] tp;
        logic [6:0] ip;
        logic [6:0] op;
    } func_sel_s;
    // Sampled levels of the selected pins, now and one cycle ago
    typedef struct packed {
        logic cnt, cnt_prev, trg, trg_prev, gate, gate_prev;
    } pin_view_s;
    // Host write strobes for one function
    typedef struct packed {
        logic we_mode, we_sel, we_prld, we_aux;
        logic [31:0] data;
    } host_wr_s;
    // What a function shows to the rest of the block
    typedef struct packed {
        logic [15:0] work;
        logic [15:0] aux;
        func_cfg_s cfg;
        func_sel_s sel;
        logic level;
        logic drives;
    } func_out_s;
endpackage

// ===== design/pin_sync.sv
// Two-flop synchroniser for the real pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    // First stage feeds only the second stage
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sync_s;
    sync_s st, next_st;
    // ==================================================
    // Shift chain
    always_comb
    begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    end
    assign q = st.s2;
endmodule
`default_nettype wire

// ===== design/ppc_channel.sv
// One counting function: working and auxiliary registers and mode logic
`timescale 1ns/1ps
`default_nettype none
`include "ppc_cfg.svh"
module ppc_channel (
    input wire logic pclk,
    input wire logic presetn,
    input wire ppc_pkg::host_wr_s host_wr,
    input wire ppc_pkg::pin_view_s view,
    output ppc_pkg::func_out_s fout
);
    import ppc_pkg::*;
    typedef struct packed {
        func_cfg_s cfg;
        func_sel_s sel;
        logic [15:0] prld;
        logic [15:0] work;
        logic [15:0] aux;
        logic tog;
    } chan_s;
    chan_s st, next_st;
    logic [6:0] base; // Mode code without the down offset
    logic down; // Count downward
    logic cnt_ev, trg_ev, gate_ev;
    logic [15:0] step;
    logic act;
    // Edge selector: 0 locked, 1 rising, 2 falling, 3 both
    function automatic logic hit(input logic [1:0] sel, input logic lvl, input logic prev);
        unique case (sel)
            `EDGE_RISE: hit = lvl & ~prev;
            `EDGE_FALL: hit = ~lvl & prev;
            `EDGE_BOTH: hit = lvl ^ prev;
            default: hit = 1'b0;
        endcase
    endfunction
    // ==================================================
    // Mode decode, host writes and counting
    always_comb
    begin
        next_st = st;
        down = (st.cfg.mode >= `MODE_DOWN);
        base = down ? st.cfg.mode - `MODE_DOWN : st.cfg.mode;
        cnt_ev = hit(st.cfg.iedg, view.cnt, view.cnt_prev);
        trg_ev = hit(st.cfg.tedg, view.trg, view.trg_prev);
        gate_ev = hit(st.cfg.tedg, view.gate, view.gate_prev);
        step = down ? st.work - 16'h0001 : st.work + 16'h0001;
        if (host_wr.we_mode)
        begin
            // Reconfiguring halts the function for this cycle and preloads
            next_st.cfg.mode = host_wr.data[`MODE_LSB +: 7];
            next_st.cfg.opol = host_wr.data[`OPOL_BIT];
            next_st.cfg.iedg = host_wr.data[`IEDG_LSB +: 2];
            next_st.cfg.tedg = host_wr.data[`TEDG_LSB +: 2];
            next_st.work = st.prld;
            next_st.aux = st.prld;
            next_st.tog = 1'b0;
        end
        else
        begin
            if (host_wr.we_sel)
            begin
                // Each selector sits in its own byte, as the read-back shows it
                next_st.sel.op = host_wr.data[`OP_LSB +: 7];
                next_st.sel.ip = host_wr.data[`IP_LSB +: 7];
                next_st.sel.tp = host_wr.data[`TP_LSB +: 7];
                next_st.sel.gp = host_wr.data[`GP_LSB +: 7];
            end
            if (host_wr.we_prld)
                next_st.prld = host_wr.data[15:0];
            if (host_wr.we_aux)
                next_st.aux = host_wr.data[15:0];
            // Hardware updates come after host writes, so a sample wins
            unique case (base)
                `MODE_INC:
                    if (cnt_ev)
                        next_st.work = step;
                `MODE_HALF:
                    if (cnt_ev && step >= st.aux)
                    begin
                        next_st.tog = ~st.tog;
                        next_st.work = `WORD_RST;
                    end
                    else if (cnt_ev)
                        next_st.work = step;
                `MODE_WIDTH:
                    if (trg_ev)
                        next_st.work = `WORD_RST;
                    else if (cnt_ev)
                        next_st.work = step;
                `MODE_GATED:
                    if (gate_ev)
                    begin
                        next_st.aux = st.work;
                        next_st.work = `WORD_RST;
                    end
                    else if (cnt_ev && view.gate == st.cfg.opol)
                        next_st.work = step;
                default: ; // Pin I/O, idle and unsupported codes hold state
            endcase
        end
        // Function's own active level
        unique case (base)
            `MODE_INC: act = (st.work >= st.aux);
            `MODE_HALF: act = st.tog;
            `MODE_WIDTH: act = (st.work <= st.aux);
            `MODE_GATED: act = (st.work == `CNT_MAX);
            default: act = 1'b0;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    end
    assign fout.work = st.work;
    assign fout.aux = st.aux;
    assign fout.cfg = st.cfg;
    assign fout.sel = st.sel;
    // Gated mode output is plain active high; opol picks the gate level
    assign fout.level = (base == `MODE_GATED) ? act : (st.cfg.opol ? act : ~act);
    assign fout.drives = (base >= `MODE_INC) && (base <= `MODE_GATED);
endmodule
`default_nettype wire

// ===== design/pulse_processor.sv
// Pulse processor top: APB registers, pin resolution and function array
//
// Function
// - Mode code 0 to 16 per function
// - Code plus 100 counts down
// - Pin I/O mode: host commands only
// - Pin levels readable in any mode
// - Reset: pin I/O, outputs, driven low
// - Code 1 does nothing
// - Increment; output while work >= aux
// - Aux changed by host only
// - Half-duty: toggle on reaching aux
// - Configuration preloads work and aux
// - Width: trigger clears; output work <= aux
// - Width compare is less-or-equal
// - Gated: gate edge samples, then clears
// - Polarity picks counting gate level
// - Gated output at maximum count
// - Gated preloads aux and work
// - Output may be real, hidden, dummy
// - Input code zero is internal cycle
// - Direction in groups of four pins
// - Edge codes: lock, rise, fall, both
// - Pins 1-32 real, 33-48 hidden, 49-64 dummy
// - Polarity 0 low, 1 high active
// - Internal cycle period five microseconds
`timescale 1ns/1ps
`default_nettype none
`include "ppc_cfg.svh"
module pulse_processor #(
    parameter int NUM_FUNC = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] pin_in,
    output logic [31:0] pin_out,
    output logic [31:0] pin_oe_n
);
    import ppc_pkg::*;

    // ==================================================
    // State of the block
    typedef struct packed {
        logic pready; // Access phase answer
        logic pslverr; // Unmapped address answer
        logic [31:0] prdata; // Captured read data
        logic [31:0] static_lat; // Host-set levels of the real pins
        logic [3:0] dir; // One input flag per group of four
        logic [64:0] lvl; // Pin levels, bit 0 is the internal cycle
        logic [64:0] prev; // Levels one cycle ago, for edges
        logic [8:0] cyc_cnt; // Half period counter of the cycle
        logic cyc; // Internal cycle square wave
        logic [31:0] pin_out; // Real pin output levels
        logic [31:0] pin_oe_n; // Low while driving the pin
    } top_s;

    top_s st, next_st;

    // Last counter value in each half period of the internal cycle
    localparam logic [8:0] CYC_LAST = 9'(`CYCLE_HALF_CNT - 1);

    logic [31:0] sync_in; // Real pin inputs after synchronisation
    logic [64:0] own; // Pin is driven by some function
    logic [64:0] fval; // Level that the owning function wants
    logic [64:0] drive; // Resolved level of each output pin
    logic acc; // Completing APB access
    logic setup_acc; // First access cycle, answer prepared
    logic func_hit; // Address falls in the function region
    logic [4:0] fidx; // Function addressed
    logic [1:0] sub; // Register inside that function
    logic mapped; // Address decodes to a register
    logic [31:0] rd; // Read data before capture

    func_out_s fo [NUM_FUNC]; // Per-function outputs
    host_wr_s hw [NUM_FUNC]; // Per-function write strobes
    pin_view_s vw [NUM_FUNC]; // Per-function pin views

    // Selected pin level, any code above 64 reads as low
    function automatic logic pick(input logic [64:0] vec, input logic [6:0] idx);
        if (idx <= `PIN_LAST)
            pick = vec[idx];
        else
            pick = 1'b0;
    endfunction

    // ==================================================
    // Pin input synchronisation
    // External levels pass two flops before any edge logic sees them
    pin_sync #(
        .WIDTH(32)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(pin_in),
        .q(sync_in)
    );

    // ==================================================
    // Function array
    // Each function sees its three selected pins as registered levels
    // and the levels of the cycle before, so edges are found on pclk
    genvar g;
    generate
        for (g = 0; g < NUM_FUNC; g++)
        begin : g_func
            // Code zero on any input selector picks the internal cycle
            assign vw[g].cnt = pick(st.lvl, fo[g].sel.ip);
            assign vw[g].cnt_prev = pick(st.prev, fo[g].sel.ip);
            assign vw[g].trg = pick(st.lvl, fo[g].sel.tp);
            assign vw[g].trg_prev = pick(st.prev, fo[g].sel.tp);
            assign vw[g].gate = pick(st.lvl, fo[g].sel.gp);
            assign vw[g].gate_prev = pick(st.prev, fo[g].sel.gp);
            ppc_channel u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .host_wr(hw[g]),
                .view(vw[g]),
                .fout(fo[g])
            );
        end
    endgenerate

    // ==================================================
    // Address decode
    // Low words hold the static pin registers; each function has
    // four words starting at 0x200 plus sixteen times its number
    always_comb
    begin
        fidx = paddr[8:4];
        sub = paddr[3:2];
        func_hit = (paddr[11:9] == `FUNC_REGION)
            && ({1'b0, paddr[8:4]} < 6'(NUM_FUNC));
        unique case (paddr)
            `OFS_PIN_DATA, `OFS_PIN_SET, `OFS_PIN_CLR,
            `OFS_PIN_DIR, `OFS_VIRT_READ: mapped = 1'b1;
            default: mapped = func_hit;
        endcase
        // The answer is prepared in the first access cycle
        setup_acc = psel & penable & ~st.pready;
        // The write lands on the edge where pready is seen high
        acc = psel & penable & st.pready;
    end

    // ==================================================
    // Function write strobes
    // Only the addressed function sees a strobe, for one cycle
    always_comb
    begin
        for (int f = 0; f < NUM_FUNC; f++)
        begin
            hw[f].data = pwdata;
            hw[f].we_mode = 1'b0;
            hw[f].we_sel = 1'b0;
            hw[f].we_prld = 1'b0;
            hw[f].we_aux = 1'b0;
            if (acc && pwrite && func_hit && (fidx == 5'(f)))
            begin
                hw[f].we_mode = (sub == `SUB_MODE);
                hw[f].we_sel = (sub == `SUB_SEL);
                hw[f].we_prld = (sub == `SUB_WORK);
                hw[f].we_aux = (sub == `SUB_AUX);
            end
        end
    end

    // ==================================================
    // Read data multiplexer
    always_comb
    begin
        rd = '0;
        if (func_hit)
        begin
            unique case (sub)
                `SUB_MODE:
                begin
                    rd[`MODE_LSB +: 7] = fo[fidx].cfg.mode;
                    rd[`OPOL_BIT] = fo[fidx].cfg.opol;
                    rd[`IEDG_LSB +: 2] = fo[fidx].cfg.iedg;
                    rd[`TEDG_LSB +: 2] = fo[fidx].cfg.tedg;
                end
                `SUB_SEL:
                begin
                    rd[`OP_LSB +: 7] = fo[fidx].sel.op;
                    rd[`IP_LSB +: 7] = fo[fidx].sel.ip;
                    rd[`TP_LSB +: 7] = fo[fidx].sel.tp;
                    rd[`GP_LSB +: 7] = fo[fidx].sel.gp;
                end
                `SUB_WORK: rd[15:0] = fo[fidx].work;
                `SUB_AUX: rd[15:0] = fo[fidx].aux;
            endcase
        end
        else
        begin
            unique case (paddr)
                // Levels of the real pins, whatever mode owns them
                `OFS_PIN_DATA: rd = st.lvl[32:1];
                `OFS_PIN_SET, `OFS_PIN_CLR: rd = st.static_lat;
                `OFS_PIN_DIR: rd[3:0] = st.dir;
                `OFS_VIRT_READ: rd = st.lvl[64:33];
                default: rd = '0;
            endcase
        end
    end

    // ==================================================
    // Pin ownership
    // A function in a counting mode with a nonzero output code owns that
    // pin; if two functions name the same pin the higher number wins
    always_comb
    begin
        own = '0;
        fval = '0;
        for (int f = 0; f < NUM_FUNC; f++)
        begin
            if (fo[f].drives && fo[f].sel.op != 7'h00 && fo[f].sel.op <= `PIN_LAST)
            begin
                own[fo[f].sel.op] = 1'b1;
                fval[fo[f].sel.op] = fo[f].level;
            end
        end
        // Unowned real pins follow the static latch, virtual ones read low
        drive = '0;
        for (int p = 1; p <= 64; p++)
        begin
            if (own[p])
                drive[p] = fval[p];
            else if (p <= 32)
                drive[p] = st.static_lat[p-1];
        end
    end

    // ==================================================
    // Next state
    always_comb
    begin
        next_st = st;
        // Internal cycle: toggles every half period
        if (st.cyc_cnt == CYC_LAST)
        begin
            next_st.cyc_cnt = 9'h000;
            next_st.cyc = ~st.cyc;
        end
        else
            next_st.cyc_cnt = st.cyc_cnt + 9'h001;
        // Pin levels and drivers
        next_st.prev = st.lvl;
        next_st.lvl[0] = st.cyc;
        for (int i = 0; i < 32; i++)
        begin
            // Pins 9..16 and 25..32 are always outputs; the others
            // take the flag of their group of four
            if (!i[3] && st.dir[{i[4], i[2]}])
            begin
                next_st.lvl[i+1] = sync_in[i];
                next_st.pin_oe_n[i] = 1'b1;
            end
            else
            begin
                next_st.lvl[i+1] = drive[i+1];
                next_st.pin_oe_n[i] = 1'b0;
            end
            next_st.pin_out[i] = drive[i+1];
        end
        // Hidden and dummy pins are internal flops only
        next_st.lvl[64:33] = drive[64:33];
        // APB answer: pready rises one cycle into the access phase
        next_st.pready = setup_acc;
        next_st.pslverr = setup_acc & ~mapped;
        if (setup_acc)
            next_st.prdata = mapped ? rd : 32'h0000_0000;
        // Static pin commands from the host
        if (acc && pwrite && !func_hit)
        begin
            unique case (paddr)
                `OFS_PIN_DATA: next_st.static_lat = pwdata;
                `OFS_PIN_SET: next_st.static_lat = st.static_lat | pwdata;
                `OFS_PIN_CLR: next_st.static_lat = st.static_lat & ~pwdata;
                `OFS_PIN_DIR: next_st.dir = pwdata[3:0];
                default: ; // Read-only or unmapped
            endcase
        end
    end

    // ==================================================
    // State register
    // Reset leaves every pin an output driven low and every function in
    // pin I/O mode (the function registers clear to mode zero)
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
            st.static_lat <= `STATIC_RST;
            st.dir <= `DIR_RST;
            st.pin_oe_n <= 32'h0000_0000;
        end
        else
            st <= next_st;
    end

    // ==================================================
    // Outputs straight from the state flops
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign pin_out = st.pin_out;
    assign pin_oe_n = st.pin_oe_n;
endmodule
`default_nettype wire

// ===== verif/ppc_monitor.sv
// Concurrent checks on the pulse processor's bus and pin ports
`timescale 1ns/1ps
`default_nettype none
`include "ppc_cfg.svh"
module ppc_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] pin_in,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe_n
);
    import ppc_pkg::*;
    // ==================================================
    // Helpers
    logic dir_wr; // Completed write to the direction register
    assign dir_wr = pready && pwrite && !pslverr && paddr == `OFS_PIN_DIR;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ==================================================
    // Bus handshake
    ready_after_access_a: assert property ($rose(psel && penable) |=> pready)
        else $error("pready not one cycle after access");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    err_data_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("pslverr without pready or with data");
    unmapped_err_a: assert property (pready && paddr[11:8] == 4'h1 |-> pslverr)
        else $error("unmapped access not refused");
    // ==================================================
    // Pin direction; a stuck or stray enable would show here
    reset_pins_low_a: assert property ($rose(presetn) |-> pin_out == 32'h0 && pin_oe_n == 32'h0)
        else $error("pins not driven low after reset");
    fixed_outputs_a: assert property (pin_oe_n[15:8] == 8'h0 && pin_oe_n[31:24] == 8'h0)
        else $error("output-only pin released");
    dir_groups_a: assert property (pin_oe_n[3:0] inside {4'h0, 4'hF} && pin_oe_n[7:4] inside {4'h0, 4'hF} && pin_oe_n[19:16] inside {4'h0, 4'hF} && pin_oe_n[23:20] inside {4'h0, 4'hF})
        else $error("direction not in groups of four");
    dir_cause_a: assert property ($changed(pin_oe_n) |-> $past(dir_wr) || $past(dir_wr, 2))
        else $error("direction changed without a write");
    // ==================================================
    // Main scenarios reached
    cover property (pslverr);
    cover property ($rose(pin_out[8]));
    cover property ($changed(pin_oe_n));
endmodule
`default_nettype wire

// ===== verif/pin_model.sv
// Far-side pin model: outside drivers meeting the block's pin drivers
`timescale 1ns/1ps
`default_nettype none
module pin_model (
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe_n,
    input wire logic [31:0] ext_val,
    output logic [31:0] pin_in
);
    // Outside source drives only released pins, so no two drivers fight
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_val);
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the pulse processor
`timescale 1ns/1ps
`default_nettype none
`include "ppc_cfg.svh"
module tb_top;
    import ppc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, ext_val = 32'h0, prdata, pin_in, pin_out, pin_oe_n, rd;
    logic pready, pslverr, err;
    int n_fail = 0, cmp_count = 0;
    // Count table: mode word, expected work, expected pin 9
    logic [31:0] cm [7] = '{32'h102, 32'h1102, 32'h2102, 32'h3102, 32'h1002, 32'h1166, 32'h1101};
    logic [15:0] cw [7] = '{16'h5, 16'h7, 16'h7, 16'h9, 16'h7, 16'h3, 16'h5};
    logic cp [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    pulse_processor i_pulse_processor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe_n);
    pin_model i_pin_model (.pin_out, .pin_oe_n, .ext_val, .pin_in);
    // ==================================================
    // Clock and watchdog
    initial
    begin
        forever #5 pclk = ~pclk;
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        close_out();
    end
    // ==================================================
    // Shared tasks
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask
    // One transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input string s, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(s, e, rd);
    endtask
    task automatic cfg(input logic [31:0] s, input logic [15:0] p, input logic [31:0] m);
        wr(12'h204, s);
        wr(12'h208, {16'h0, p});
        wr(12'h200, m);
    endtask
    // Pin edges are spaced well beyond the sync and count latency
    task automatic tog(input int b, input int n);
        repeat (n)
        begin
            ext_val[b] <= ~ext_val[b];
            repeat (8) @(posedge pclk);
        end
    endtask
    task automatic pin_chk(input int b, input logic e);
        repeat (4) @(posedge pclk);
        chk($sformatf("pin_out[%0d]", b), {31'h0, e}, {31'h0, pin_out[b]});
    endtask
    // ==================================================
    // Scenarios
    task automatic t_static;
        chk("pin_oe_n", 32'h0, pin_oe_n);
        rdc(12'h200, "mode", 32'h0);
        rdc(12'h100, "unmapped", 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        wr(`OFS_PIN_DATA, 32'hA5A5_0F0F);
        wr(`OFS_PIN_SET, 32'h0000_00F0);
        wr(`OFS_PIN_CLR, 32'h0000_0F0F);
        rdc(`OFS_PIN_DATA, "levels", 32'hA5A5_00F0);
        chk("pin_out", 32'hA5A5_00F0, pin_out);
        wr(`OFS_PIN_DATA, 32'h0);
        wr(`OFS_PIN_DIR, 32'h1);
        pin_chk(0, 1'b0);
        chk("pin_oe_n", 32'h0000_000F, pin_oe_n);
        $display("static test done");
    endtask
    task automatic t_count;
        for (int i = 0; i < 7; i++)
        begin
            cfg(32'h109, 16'h5, cm[i]);
            rdc(12'h20C, "aux", 32'h5);
            wr(12'h20C, 32'h8);
            tog(0, 4);
            rdc(12'h208, "work", {16'h0, cw[i]});
            rdc(12'h20C, "aux", 32'h8);
            pin_chk(8, cp[i]);
        end
        $display("count test done");
    endtask
    task automatic t_half_width;
        cfg(32'h109, 16'h2, 32'h1103);
        tog(0, 2);
        rdc(12'h208, "work", 32'h0);
        pin_chk(8, 1'b1);
        tog(0, 4);
        pin_chk(8, 1'b0);
        cfg(32'h2_010A, 16'h2, 32'h1_1104);
        pin_chk(9, 1'b1);
        tog(0, 2);
        pin_chk(9, 1'b0);
        tog(1, 2);
        rdc(12'h208, "work", 32'h0);
        pin_chk(9, 1'b1);
        $display("half and width test done");
    endtask
    task automatic t_gated;
        cfg(32'h300_010B, 16'hFFFE, 32'h2_1105);
        rdc(12'h20C, "aux", 32'hFFFE);
        tog(0, 2);
        rdc(12'h208, "work", 32'hFFFE);
        tog(2, 1);
        tog(0, 2);
        rdc(12'h208, "work", 32'hFFFF);
        pin_chk(10, 1'b1);
        tog(2, 1);
        rdc(12'h20C, "aux", 32'hFFFF);
        rdc(12'h208, "work", 32'h0);
        pin_chk(10, 1'b0);
        $display("gated test done");
    endtask
    // Internal cycle on a hidden pin, then a reset in mid-run
    task automatic t_cycle;
        logic [15:0] w0;
        cfg(32'h21, 16'h3, 32'h1102);
        rdc(`OFS_VIRT_READ, "hidden pin 33", 32'h1);
        apb(1'b0, 12'h208, 32'h0);
        w0 = rd[15:0];
        // Reads sample the counter 1000 clocks apart: two cycle rises
        repeat (996) @(posedge pclk);
        rdc(12'h208, "cycle count", {16'h0, w0 + 16'h0002});
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("pin_oe_n", 32'h0, pin_oe_n);
        rdc(12'h200, "mode", 32'h0);
        $display("cycle and reset test done");
    endtask
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_static();
        t_count();
        t_half_width();
        t_gated();
        t_cycle();
        close_out();
    end
endmodule
bind pulse_processor ppc_monitor i_ppc_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n));
`default_nettype wire
